/* File: pss_pkg.sv */
// Constants, state encoding and field positions for the power state sequencer
package pss_pkg;

    // Supervised pin inputs, one bit each in the synchroniser vector
    localparam int PIN_W         = 8;
    localparam int PIN_VIN       = 0;
    localparam int PIN_EN_UV     = 1;
    localparam int PIN_DRV_REG   = 2;
    localparam int PIN_EXT_DRV   = 3;
    localparam int PIN_LOGIC     = 4;
    localparam int PIN_BACKUP    = 5;
    localparam int PIN_DIM0      = 6;
    localparam int PIN_DIM1      = 7;
    localparam logic [PIN_W-1:0] PIN_RESET_VAL = 8'h00;

    localparam int CHAN_N = 2;

    // Wake delay from sleep to active; value is a plain default
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAKE_TIME_NS  = 100000;
    localparam int WAKE_CYCLES   = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W         = 32;
    localparam logic [CNT_W-1:0] CNT_RESET_VAL = 32'h0000_0000;

    typedef enum logic [1:0] {
        PSS_SLEEP  = 2'b00,
        PSS_IDLE   = 2'b01,
        PSS_BACKUP = 2'b10,
        PSS_ACTIVE = 2'b11
    } pss_state_t;

    localparam pss_state_t STATE_RESET_VAL = PSS_SLEEP;

endpackage

/* File: pss_filt_if.sv */
// Filtered input levels passed from the input filter to the sequencer
`timescale 1ns/1ps
interface pss_filt_if;
    import pss_pkg::*;
    logic [PIN_W-1:0] level;

    modport src (output level);
    modport dst (input level);
endinterface

/* File: pss_input_filter.sv */
// Three-stage synchroniser and agreement filter for the pin inputs
`timescale 1ns/1ps
module pss_input_filter
    import pss_pkg::*;
(
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    input  wire logic [PIN_W-1:0] pinRaw,
    pss_filt_if.src               filt
);
    logic [PIN_W-1:0] sync1_q;
    logic [PIN_W-1:0] sync2_q;
    logic [PIN_W-1:0] sync3_q;
    logic [PIN_W-1:0] stable_q;
    logic [PIN_W-1:0] stable_d;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_q <= PIN_RESET_VAL;
            sync2_q <= PIN_RESET_VAL;
            sync3_q <= PIN_RESET_VAL;
        end
        else
        begin
            sync1_q <= pinRaw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // Taken combinationally so the filter adds no extra cycle
    always_comb
    begin
        for (int i = 0; i < PIN_W; i++)
        begin
            stable_d[i] = (sync2_q[i] == sync3_q[i]) ? sync3_q[i] : stable_q[i];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stable_q <= PIN_RESET_VAL;
        end
        else
        begin
            stable_q <= stable_d;
        end
    end

    assign filt.level = stable_d;

endmodule // pss_input_filter

/* File: power_state_sequencer.sv */
// Power state sequencer: chooses sleep, idle, backup or active and gates the device
`timescale 1ns/1ps
module power_state_sequencer
    import pss_pkg::*;
#(
    parameter int WAKE_CNT = WAKE_CYCLES
)
(
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              mainSupplyLevel,
    input  wire logic              enableUndervoltagePin,
    input  wire logic              driverRegulatorLevel,
    input  wire logic              externalDriverSupplyLevel,
    input  wire logic              logicSupplyLevel,
    input  wire logic              backupModeInput,
    input  wire logic [CHAN_N-1:0] channelDimmingInput,
    input  wire logic              standbyRequestBit,
    input  wire logic [CHAN_N-1:0] channelDimmingControlBit,
    output logic [1:0]             powerState,
    output logic                   serialRegReset,
    output logic                   serialEnable,
    output logic                   serialReadOnly,
    output logic                   driverRegulatorEnable,
    output logic [CHAN_N-1:0]      gateSwitchEnable,
    output logic                   transferErrorFlagSet
);
    pss_filt_if filt ();

    logic [PIN_W-1:0] pinRaw;
    logic             vinOk;
    logic             enOk;
    logic             drvRegOk;
    logic             extDrvOk;
    logic             logicOk;
    logic             backupReq;
    logic [CHAN_N-1:0] dimIn;

    pss_state_t       state_q;
    pss_state_t       state_d;
    logic [CNT_W-1:0] wakeCnt_q;
    logic             wakeDone;
    logic             regReset_d;
    logic             backupEnter;
    logic [CHAN_N-1:0] gate_d;

    logic [1:0]        powerState_q;
    logic              serialRegReset_q;
    logic              serialEnable_q;
    logic              serialReadOnly_q;
    logic              driverRegEnable_q;
    logic [CHAN_N-1:0] gateSwitch_q;
    logic              errFlagSet_q;

    assign pinRaw = {channelDimmingInput[1], channelDimmingInput[0], backupModeInput,
                     logicSupplyLevel, externalDriverSupplyLevel, driverRegulatorLevel,
                     enableUndervoltagePin, mainSupplyLevel};

    pss_input_filter u_filter (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .pinRaw   (pinRaw),
        .filt     (filt.src)
    );

    assign vinOk     = filt.level[PIN_VIN];
    assign enOk      = filt.level[PIN_EN_UV];
    assign drvRegOk  = filt.level[PIN_DRV_REG];
    assign extDrvOk  = filt.level[PIN_EXT_DRV];
    assign logicOk   = filt.level[PIN_LOGIC];
    assign backupReq = filt.level[PIN_BACKUP];
    assign dimIn     = {filt.level[PIN_DIM1], filt.level[PIN_DIM0]};

    assign wakeDone = (wakeCnt_q >= CNT_W'(WAKE_CNT));

    // Next state; the branch order is the priority order
    always_comb
    begin
        state_d = state_q;
        if (!vinOk || !enOk)
        begin
            state_d = PSS_SLEEP;
        end
        else if (!logicOk)
        begin
            state_d = PSS_IDLE;
        end
        else if (backupReq)
        begin
            state_d = PSS_BACKUP;
        end
        else if (standbyRequestBit)
        begin
            state_d = PSS_IDLE;
        end
        else if (state_q != PSS_SLEEP || wakeDone)
        begin
            state_d = PSS_ACTIVE;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_q <= STATE_RESET_VAL;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Wake timer runs only while sleeping with the supplies that allow a wake
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wakeCnt_q <= CNT_RESET_VAL;
        end
        else if (state_q != PSS_SLEEP || !vinOk || !enOk)
        begin
            wakeCnt_q <= CNT_RESET_VAL;
        end
        else if (!wakeDone)
        begin
            wakeCnt_q <= wakeCnt_q + CNT_W'(1);
        end
    end

    assign backupEnter = (state_d == PSS_BACKUP) && (state_q != PSS_BACKUP);

    // Register reset held in sleep and logic undervoltage, pulsed on backup entry
    assign regReset_d = (state_d == PSS_SLEEP) || !logicOk
                     || backupEnter;

    // Backup regulation follows the backup circuit, not the dimming controls
    always_comb
    begin
        for (int i = 0; i < CHAN_N; i++)
        begin
            gate_d[i] = 1'b0;
            if (drvRegOk && extDrvOk && logicOk)
            begin
                if (state_d == PSS_ACTIVE)
                begin
                    gate_d[i] = dimIn[i] || channelDimmingControlBit[i];
                end
                else if (state_d == PSS_BACKUP)
                begin
                    gate_d[i] = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            powerState_q      <= STATE_RESET_VAL;
            serialRegReset_q  <= 1'b1;
            serialEnable_q    <= 1'b0;
            serialReadOnly_q  <= 1'b0;
            driverRegEnable_q <= 1'b0;
            gateSwitch_q      <= '0;
        end
        else
        begin
            powerState_q      <= state_d;
            serialRegReset_q  <= regReset_d;
            serialEnable_q    <= (state_d != PSS_SLEEP) && logicOk;
            serialReadOnly_q  <= (state_d == PSS_BACKUP);
            driverRegEnable_q <= (state_d != PSS_SLEEP);
            gateSwitch_q      <= gate_d;
        end
    end

    // Power-up reset counts as a reset source, hence the set value under reset
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            errFlagSet_q <= 1'b1;
        end
        else
        begin
            // Backup entry from sleep shows no rising reset, so it sets the flag itself
            errFlagSet_q <= (regReset_d && !serialRegReset_q) || backupEnter;
        end
    end

    assign powerState            = powerState_q;
    assign serialRegReset        = serialRegReset_q;
    assign serialEnable          = serialEnable_q;
    assign serialReadOnly        = serialReadOnly_q;
    assign driverRegulatorEnable = driverRegEnable_q;
    assign gateSwitchEnable      = gateSwitch_q;
    assign transferErrorFlagSet  = errFlagSet_q;

endmodule // power_state_sequencer

/* File: pss_seq_chk.sv */
// Concurrent checks on the power state sequencer ports
`timescale 1ns/1ps
module pss_seq_chk
    import pss_pkg::*;
#(
    parameter int WAKE_CNT = WAKE_CYCLES
)
(
    input wire logic              core_clk,
    input wire logic              arst_n,
    input wire logic              mainSupplyLevel,
    input wire logic              enableUndervoltagePin,
    input wire logic              driverRegulatorLevel,
    input wire logic              externalDriverSupplyLevel,
    input wire logic              logicSupplyLevel,
    input wire logic              backupModeInput,
    input wire logic [CHAN_N-1:0] channelDimmingInput,
    input wire logic [CHAN_N-1:0] channelDimmingControlBit,
    input wire logic [1:0]        powerState,
    input wire logic              serialRegReset,
    input wire logic              serialEnable,
    input wire logic              serialReadOnly,
    input wire logic              driverRegulatorEnable,
    input wire logic [CHAN_N-1:0] gateSwitchEnable,
    input wire logic              transferErrorFlagSet
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic [31:0] sleepRun_q;
    // Length of the current run of sleep cycles
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            sleepRun_q <= 32'h0000_0000;
        else if (powerState == PSS_SLEEP)
            sleepRun_q <= sleepRun_q + 32'h0000_0001;
        else
            sleepRun_q <= 32'h0000_0000;
    end
    sequence backupEntry;
        powerState != PSS_BACKUP ##1 powerState == PSS_BACKUP;
    endsequence
    sequence wakeEntry;
        powerState == PSS_SLEEP ##1 powerState == PSS_ACTIVE;
    endsequence
    chk_sleep_all_off: assert property (powerState == PSS_SLEEP |-> gateSwitchEnable == 2'h0
        && !serialEnable && serialRegReset && !driverRegulatorEnable) else $error("sleep outputs on");
    chk_idle_no_switch: assert property (powerState == PSS_IDLE |-> gateSwitchEnable == 2'h0)
        else $error("switching in idle");
    // Pin to registered output takes four edges, seen at the fifth sample
    chk_logic_uv_block: assert property ((!logicSupplyLevel)[*5]
        |-> gateSwitchEnable == 2'h0 && !serialEnable && serialRegReset)
        else $error("logic undervoltage not blocking");
    chk_drv_uv_stop: assert property (
        (!driverRegulatorLevel || !externalDriverSupplyLevel)[*5] |-> gateSwitchEnable == 2'h0)
        else $error("driver undervoltage still switching");
    chk_enable_uv_sleep: assert property ((!enableUndervoltagePin)[*5]
        |-> powerState == PSS_SLEEP && !driverRegulatorEnable && !serialEnable)
        else $error("enable undervoltage ignored");
    chk_backup_entry: assert property (backupEntry |-> serialRegReset
        && transferErrorFlagSet && serialReadOnly)
        else $error("backup entry without register reset");
    // Wake counter plus the leaving edge: more than WAKE_CNT sleep cycles
    chk_wake_delay: assert property (wakeEntry |-> sleepRun_q > WAKE_CNT)
        else $error("active entered before wake delay");
    // Filter uses the pin three and four samples back
    chk_dim_gate: assert property (powerState == PSS_ACTIVE && gateSwitchEnable[0]
        |-> $past(channelDimmingControlBit[0]) || $past(channelDimmingInput[0], 3)
        || $past(channelDimmingInput[0], 4)) else $error("channel switching without dimming");
    chk_reset_flag: assert property ($rose(serialRegReset) |-> transferErrorFlagSet)
        else $error("register reset without error flag");
    chk_uv_priority: assert property ((!logicSupplyLevel && backupModeInput
        && enableUndervoltagePin && mainSupplyLevel)[*5] |-> powerState == PSS_IDLE)
        else $error("backup taken over logic undervoltage");
endmodule // pss_seq_chk

bind power_state_sequencer pss_seq_chk #(.WAKE_CNT(WAKE_CNT)) pss_seq_chk_i (.*);

/* File: pss_supply_model.sv */
// Supply monitors and backup circuit seen from the sequencer
`timescale 1ns/1ps
module pss_supply_model
(
    input  wire logic       core_clk,
    input  wire logic [5:0] levelReq,
    output logic [5:0]      levels
);
    logic [5:0] levels_q = 6'h00;
    // Levels move only at the falling edge, away from sampling
    always @(negedge core_clk)
    begin
        levels_q <= levelReq;
    end
    assign levels = levels_q;
endmodule // pss_supply_model

/* File: tb_power_state_sequencer.sv */
// Directed testbench for the power state sequencer
`timescale 1ns/1ps
`define PSS_CHK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("unexpected %s: expected %h seen %h", what, exp, got); end end
module tb_power_state_sequencer;
    import pss_pkg::*;
    localparam int WAKE_N = 8;
    logic core_clk, arst_n, standbyRequestBit;
    logic [5:0] levelReq, levels;
    logic [1:0] channelDimmingInput, channelDimmingControlBit, powerState, gateSwitchEnable;
    logic serialRegReset, serialEnable, serialReadOnly;
    logic driverRegulatorEnable, transferErrorFlagSet;
    int error_cnt = 0, checks_done = 0, cycleCnt = 0;
    wire mainSupplyLevel = levels[5];
    wire enableUndervoltagePin = levels[4];
    wire driverRegulatorLevel = levels[3];
    wire externalDriverSupplyLevel = levels[2];
    wire logicSupplyLevel = levels[1];
    wire backupModeInput = levels[0];
    power_state_sequencer #(.WAKE_CNT(WAKE_N)) power_state_sequencer_i (.*);
    pss_supply_model pss_supply_model_i (
        .core_clk (core_clk),
        .levelReq (levelReq),
        .levels   (levels)
    );
    initial
    begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycleCnt++;
        if (cycleCnt == 3000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    // Filter plus registered outputs need four edges; one spare
    task automatic settle;
        repeat (5) @(negedge core_clk);
    endtask
    task automatic wait_state(input logic [1:0] st);
        int n;
        n = 0;
        while (powerState !== st && n < 100)
        begin
            @(negedge core_clk);
            n++;
        end
        `PSS_CHK("state reached", st, powerState)
    endtask
    task automatic check_wake;
        int n;
        levelReq = 6'b011110;
        settle();
        `PSS_CHK("state no main", 2'b00, powerState)
        levelReq = 6'b111110;
        n = 0;
        while (powerState !== 2'b11 && n < 100)
        begin
            @(negedge core_clk);
            n++;
        end
        `PSS_CHK("wake long enough", 1'b1, n >= WAKE_N)
        `PSS_CHK("serial on", 1'b1, serialEnable & driverRegulatorEnable & ~serialRegReset)
        `PSS_CHK("gate dark", 2'b00, gateSwitchEnable)
        `PSS_CHK("active read only", 1'b0, serialReadOnly)
        channelDimmingControlBit = 2'b01;
        repeat (2) @(negedge core_clk);
        `PSS_CHK("gate by bit", 2'b01, gateSwitchEnable)
        channelDimmingInput = 2'b10;
        settle();
        `PSS_CHK("gate by pin", 2'b11, gateSwitchEnable)
    endtask
    task automatic check_standby_backup;
        standbyRequestBit = 1'b1;
        settle();
        `PSS_CHK("standby state", 2'b01, powerState)
        `PSS_CHK("idle gate", 2'b00, gateSwitchEnable)
        `PSS_CHK("idle serial", 1'b1, serialEnable & ~serialRegReset)
        levelReq = 6'b111111;
        wait_state(2'b10);
        `PSS_CHK("entry pulse", 2'b11, {serialRegReset, transferErrorFlagSet})
        `PSS_CHK("read only", 1'b1, serialReadOnly)
        standbyRequestBit = 1'b0;
        levelReq = 6'b111110;
        wait_state(2'b11);
    endtask
    task automatic check_supply_faults;
        levelReq = 6'b110110;
        settle();
        `PSS_CHK("drv uv gate", 2'b00, gateSwitchEnable)
        `PSS_CHK("drv uv regs kept", 1'b0, serialRegReset)
        levelReq = 6'b111101;
        settle();
        `PSS_CHK("logic uv state", 2'b01, powerState)
        `PSS_CHK("logic uv serial", 2'b01, {serialEnable, serialRegReset})
        `PSS_CHK("logic uv gate", 2'b00, gateSwitchEnable)
        levelReq = 6'b111110;
        settle();
        `PSS_CHK("recovered", 2'b11, powerState)
        levelReq = 6'b101110;
        settle();
        `PSS_CHK("en uv state", 2'b00, powerState)
        `PSS_CHK("en uv outputs", 2'b01, {driverRegulatorEnable, serialRegReset})
    endtask
    initial
    begin
        arst_n = 1'b0;
        levelReq = 6'h00;
        standbyRequestBit = 1'b0;
        channelDimmingInput = 2'b00;
        channelDimmingControlBit = 2'b00;
        repeat (6) @(negedge core_clk);
        `PSS_CHK("reset flag", 1'b1, transferErrorFlagSet)
        `PSS_CHK("reset state", 3'b001, {powerState, serialRegReset})
        arst_n = 1'b1;
        check_wake();
        check_standby_backup();
        check_supply_faults();
        wrap_up();
    end
endmodule // tb_power_state_sequencer
